// [osf_pkg.sv]
// Constants, types and decode helpers for the oversampling average filter.
// Assumes a single 100 MHz core clock and a synchronous active-high reset.
package osf_pkg;

  localparam int DATA_W = 16;
  localparam int CHANNELS = 8;
  localparam int RATIO_W = 3;
  localparam int SHIFT_MAX = 6;
  localparam int ACC_W = DATA_W + SHIFT_MAX;
  localparam int CNT_W = SHIFT_MAX + 1;

  localparam logic [RATIO_W-1:0] OS_NONE = 3'h0;
  localparam logic [RATIO_W-1:0] OS_INVALID = 3'h7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int ACQ_TIME_NS = 1000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 12;

  localparam logic [1:0] GROUP_NONE = 2'h0;
  localparam logic [1:0] GROUP_BOTH = 2'h3;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_ACQ = 2'b10,
    ST_DONE = 2'b11
  } osf_state_t;

  // Code is the log2 of the ratio; 000 gives one sample
  function automatic logic [RATIO_W-1:0] osf_ratio_shift(input logic [RATIO_W-1:0] code);
    begin
      osf_ratio_shift = (code == OS_INVALID) ? OS_NONE : code;
    end
  endfunction : osf_ratio_shift

  function automatic logic [CNT_W-1:0] osf_sample_count(input logic [RATIO_W-1:0] shift);
    begin
      osf_sample_count = CNT_W'(1) << shift;
    end
  endfunction : osf_sample_count

endpackage : osf_pkg

// [osf_accum.sv]
// One channel of sample accumulation, averaging and decimation.
// Assumes load and add come from the sequencer, one sample per pulse.
`timescale 1ns/1ns
module osf_accum
  import osf_pkg::*;
#(
  parameter int DW = DATA_W,
  parameter int AW = ACC_W
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic load,
  input wire logic add,
  input wire logic [DW-1:0] sample,
  input wire logic [RATIO_W-1:0] shift,
  output logic [DW-1:0] avg_word
);
  import osf_pkg::*;

  logic signed [AW-1:0] acc_reg;
  logic signed [AW-1:0] acc_next;
  logic signed [AW-1:0] sample_ext;
  logic signed [AW-1:0] shifted;

  assign sample_ext = AW'(signed'(sample));

  always_comb
  begin
    acc_next = acc_reg;
    if (load)
    begin
      acc_next = sample_ext;
    end
    else if (add)
    begin
      acc_next = acc_reg + sample_ext;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      acc_reg <= '0;
    end
    else
    begin
      acc_reg <= acc_next;
    end
  end

  // Truncating shift: rounds toward minus infinity, no rounding bias added
  assign shifted = acc_reg >>> shift;
  assign avg_word = shifted[DW-1:0];

endmodule : osf_accum

// [osf_filter.sv]
// Oversampling sequencer, averaging filter and reference-mode control.
// Assumes a converter core that starts on a one-cycle start pulse per
// channel group and answers with conv_done plus all channel samples.
`timescale 1ns/1ns

module osf_filter
  import osf_pkg::*;
#(
  parameter int CH = CHANNELS,
  parameter int DW = DATA_W,
  parameter int ACQ_CNT = ACQ_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [RATIO_W-1:0] oversample_ratio_select,
  input wire logic sample_trigger_a,
  input wire logic sample_trigger_b,
  input wire logic reference_source_select,
  input wire logic reference_io_pin_in,
  output logic reference_io_pin_out,
  output logic reference_io_pin_oe,
  output logic bandgap_enable,
  output logic reference_ok,
  output logic conv_start_a,
  output logic conv_start_b,
  input wire logic conv_done,
  input wire logic [CH*DW-1:0] conv_data,
  output logic [CH*DW-1:0] result_data,
  output logic result_valid,
  output logic busy,
  output logic config_error
);
  import osf_pkg::*;

  localparam int HALF = CH / 2;

  osf_state_t state_reg;
  osf_state_t state_next;
  logic trig_a_reg;
  logic trig_a_next;
  logic trig_b_reg;
  logic trig_b_next;
  logic [1:0] group_reg;
  logic [1:0] group_next;
  logic [RATIO_W-1:0] shift_reg;
  logic [RATIO_W-1:0] shift_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic [TMR_W-1:0] tmr_reg;
  logic [TMR_W-1:0] tmr_next;
  logic start_a_reg;
  logic start_a_next;
  logic start_b_reg;
  logic start_b_next;
  logic valid_reg;
  logic valid_next;
  logic busy_reg;
  logic busy_next;
  logic cfg_err_reg;
  logic cfg_err_next;
  logic [CH*DW-1:0] result_reg;
  logic [CH*DW-1:0] result_next;
  logic ref_int_reg;
  logic ref_int_next;
  logic ref_ok_reg;
  logic ref_ok_next;

  logic edge_a;
  logic edge_b;
  logic acc_load;
  logic acc_add;
  logic [CH*DW-1:0] avg_flat;
  logic [CNT_W-1:0] cnt_inc;

  assign edge_a = sample_trigger_a & ~trig_a_reg;
  assign edge_b = sample_trigger_b & ~trig_b_reg;
  assign cnt_inc = cnt_reg + CNT_W'(1);
  assign acc_load = (state_reg == ST_CONV) && conv_done && (cnt_reg == '0);
  assign acc_add = (state_reg == ST_CONV) && conv_done && (cnt_reg != '0);

  genvar gi;
  generate
    for (gi = 0; gi < CH; gi = gi + 1)
    begin : g_chan
      osf_accum #(
        .DW(DW),
        .AW(ACC_W)
      ) u_accum (
        .clk(clk),
        .rst(rst),
        .load(acc_load),
        .add(acc_add),
        .sample(conv_data[gi*DW +: DW]),
        .shift(shift_reg),
        .avg_word(avg_flat[gi*DW +: DW])
      );
    end
  endgenerate

  // Sequencer
  always_comb
  begin
    state_next = state_reg;
    trig_a_next = sample_trigger_a;
    trig_b_next = sample_trigger_b;
    group_next = group_reg;
    shift_next = shift_reg;
    cnt_next = cnt_reg;
    tmr_next = tmr_reg;
    start_a_next = 1'b0;
    start_b_next = 1'b0;
    valid_next = 1'b0;
    result_next = result_reg;
    cfg_err_next = (oversample_ratio_select == OS_INVALID);
    case (state_reg)
      ST_IDLE:
      begin
        // Invalid ratio refuses the start rather than guessing a ratio
        if ((edge_a || edge_b) && (oversample_ratio_select != OS_INVALID))
        begin
          shift_next = osf_ratio_shift(oversample_ratio_select);
          cnt_next = '0;
          if (oversample_ratio_select != OS_NONE)
          begin
            // Triggers are tied while averaging, so either edge starts all
            group_next = GROUP_BOTH;
          end
          else
          begin
            group_next = {edge_b, edge_a};
          end
          start_a_next = (oversample_ratio_select != OS_NONE) | edge_a;
          start_b_next = (oversample_ratio_select != OS_NONE) | edge_b;
          state_next = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (conv_done)
        begin
          cnt_next = cnt_inc;
          if (cnt_inc == osf_sample_count(shift_reg))
          begin
            state_next = ST_DONE;
          end
          else
          begin
            tmr_next = TMR_W'(ACQ_CNT - 1);
            state_next = ST_ACQ;
          end
        end
      end
      ST_ACQ:
      begin
        // Acquisition gap before the internally timed sample
        if (tmr_reg == '0)
        begin
          start_a_next = group_reg[0];
          start_b_next = group_reg[1];
          state_next = ST_CONV;
        end
        else
        begin
          tmr_next = tmr_reg - TMR_W'(1);
        end
      end
      ST_DONE:
      begin
        for (int c = 0; c < CH; c++)
        begin
          if (group_reg[c / HALF])
          begin
            result_next[c*DW +: DW] = avg_flat[c*DW +: DW];
          end
        end
        valid_next = 1'b1;
        group_next = GROUP_NONE;
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
    busy_next = (state_next != ST_IDLE);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= ST_IDLE;
      trig_a_reg <= 1'b1;
      trig_b_reg <= 1'b1;
      group_reg <= GROUP_NONE;
      shift_reg <= OS_NONE;
      cnt_reg <= '0;
      tmr_reg <= '0;
      start_a_reg <= 1'b0;
      start_b_reg <= 1'b0;
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
      cfg_err_reg <= 1'b0;
      result_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      trig_a_reg <= trig_a_next;
      trig_b_reg <= trig_b_next;
      group_reg <= group_next;
      shift_reg <= shift_next;
      cnt_reg <= cnt_next;
      tmr_reg <= tmr_next;
      start_a_reg <= start_a_next;
      start_b_reg <= start_b_next;
      valid_reg <= valid_next;
      busy_reg <= busy_next;
      cfg_err_reg <= cfg_err_next;
      result_reg <= result_next;
    end
  end

  // Reference mode tracks reference_source_select every cycle, reset or not
  always_comb
  begin
    ref_int_next = reference_source_select;
    ref_ok_next = reference_source_select | reference_io_pin_in;
  end

  // Not reset: after power-up the mode is simply whatever reference_source_select says
  always_ff @(posedge clk)
  begin
    ref_int_reg <= ref_int_next;
    ref_ok_reg <= ref_ok_next;
  end

  assign reference_io_pin_oe = ref_int_reg;
  assign reference_io_pin_out = ref_int_reg;
  assign bandgap_enable = ref_int_reg;
  assign reference_ok = ref_ok_reg;
  assign conv_start_a = start_a_reg;
  assign conv_start_b = start_b_reg;
  assign result_data = result_reg;
  assign result_valid = valid_reg;
  assign busy = busy_reg;
  assign config_error = cfg_err_reg;

endmodule : osf_filter

// [osf_props.sv]
// Checker on the osf_filter ports.
// Assumes reset is held a few cycles first.
`timescale 1ns/1ns
module osf_props
  import osf_pkg::*;
#(
  parameter int CH = CHANNELS,
  parameter int DW = DATA_W,
  parameter int ACQ_CNT = ACQ_CYCLES
)
(
  input logic clk,
  input logic rst,
  input logic [RATIO_W-1:0] oversample_ratio_select,
  input logic sample_trigger_a,
  input logic sample_trigger_b,
  input logic reference_source_select,
  input logic reference_io_pin_in,
  input logic reference_io_pin_out,
  input logic reference_io_pin_oe,
  input logic bandgap_enable,
  input logic reference_ok,
  input logic conv_start_a,
  input logic conv_start_b,
  input logic conv_done,
  input logic [CH*DW-1:0] conv_data,
  input logic [CH*DW-1:0] result_data,
  input logic result_valid,
  input logic busy,
  input logic config_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ref;
    reference_io_pin_oe == $past(reference_source_select)
      && bandgap_enable == reference_io_pin_oe && reference_io_pin_out == reference_io_pin_oe;
  endproperty
  property p_cfg;
    !$past(rst) |-> config_error == $past(oversample_ratio_select == OS_INVALID);
  endproperty
  property p_avg;
    !$past(rst) && $rose(sample_trigger_a || sample_trigger_b) && !busy
      && oversample_ratio_select inside {[3'h1:3'h6]} |=> conv_start_a && conv_start_b && busy;
  endproperty
  property p_one;
    !$past(rst) && $rose(sample_trigger_a) && !sample_trigger_b && !busy
      && oversample_ratio_select == OS_NONE |=> conv_start_a && !conv_start_b;
  endproperty
  property p_busy;
    conv_start_a || conv_start_b |-> busy;
  endproperty
  property p_end;
    result_valid |-> !busy && $past(busy);
  endproperty
  property p_done;
    result_valid |-> $past(conv_done, 2);
  endproperty
  property p_hold;
    !$past(rst) && !result_valid |-> $stable(result_data);
  endproperty
  a_ref: assert property (p_ref) else $error("ref mode lag");
  a_cfg: assert property (p_cfg) else $error("bad code flag");
  a_avg: assert property (p_avg) else $error("no group start");
  a_one: assert property (p_one) else $error("wrong group");
  a_busy: assert property (p_busy) else $error("start idle");
  a_end: assert property (p_end) else $error("busy at end");
  a_done: assert property (p_done) else $error("early result");
  a_hold: assert property (p_hold) else $error("result moved");
  c_avg: cover property (result_valid && oversample_ratio_select != OS_NONE);
  c_cfg: cover property (config_error);
  c_ext: cover property ($fell(reference_io_pin_oe));
endmodule : osf_props
bind osf_filter osf_props #(.CH(CH), .DW(DW), .ACQ_CNT(ACQ_CNT)) props_u (.*);

// [osf_core_model.sv]
// Converter core stand-in answering each start with all samples.
// Assumes one-cycle starts; slow stretches the answer.
`timescale 1ns/1ns
module osf_core_model
  import osf_pkg::*;
(
  input logic clk,
  input logic slow,
  input logic conv_start_a,
  input logic conv_start_b,
  output logic conv_done = 1'b0,
  output logic [CHANNELS*DATA_W-1:0] conv_data = '0
);
  int k = 0;
  int cnt = -1;
  function automatic logic [DATA_W-1:0] smp(int n, int c);
    return DATA_W'(c * 4097 + n * 3 - 20);
  endfunction : smp
  always @(posedge clk)
  begin
    conv_done <= 1'b0;
    // Stale data scrambled so nothing leans on it
    conv_data <= ~conv_data;
    if (conv_start_a || conv_start_b)
      cnt <= slow ? 5 : 0;
    else if (cnt > 0)
      cnt <= cnt - 1;
    else if (cnt == 0)
    begin
      cnt <= -1;
      conv_done <= 1'b1;
      k <= k + 1;
      for (int c = 0; c < CHANNELS; c++)
        conv_data[c*DATA_W +: DATA_W] <= smp(k, c);
    end
  end
endmodule : osf_core_model

// [tb.sv]
// Self-checking bench for osf_filter with a core model.
// Assumes a 100 MHz clock and a short acquisition count.
`timescale 1ns/1ns
module tb;
  import osf_pkg::*;
  logic clk = 0, rst = 1, trg_a = 0, trg_b = 0, sel = 1, ext = 1, slow = 0;
  logic [RATIO_W-1:0] os = OS_NONE;
  logic oe, out, bg, ok, st_a, st_b, done, valid, busy, cerr;
  logic [127:0] cdata, res, exp_res = '0;
  int error_cnt = 0, total_checks = 0;
  wire pin = oe ? out : ext;
  always #5 clk = ~clk;
  osf_filter #(.ACQ_CNT(2)) dut_u (.clk(clk), .rst(rst), .oversample_ratio_select(os),
    .sample_trigger_a(trg_a), .sample_trigger_b(trg_b), .reference_source_select(sel),
    .reference_io_pin_in(pin), .reference_io_pin_out(out), .reference_io_pin_oe(oe),
    .bandgap_enable(bg), .reference_ok(ok), .conv_start_a(st_a), .conv_start_b(st_b),
    .conv_done(done), .conv_data(cdata), .result_data(res), .result_valid(valid),
    .busy(busy), .config_error(cerr));
  osf_core_model core_u (.clk(clk), .slow(slow), .conv_start_a(st_a),
    .conv_start_b(st_b), .conv_done(done), .conv_data(cdata));
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] avg(int k0, int n, int c);
    int s;
    s = 0;
    for (int j = 0; j < n; j++)
      s += $signed(core_u.smp(k0 + j, c));
    return 16'(s >>> $clog2(n));
  endfunction : avg
  task automatic seq(input logic [2:0] code, input logic a, input logic b, input logic s);
    int k0, n, ns, nv;
    k0 = core_u.k;
    n = 1 << code;
    os = code;
    slow = s;
    tick;
    trg_a = a;
    trg_b = b;
    tick;
    chk(st_a, a | (code != 0));
    chk(st_b, b | (code != 0));
    chk(busy, 1'h1);
    trg_a = 0;
    trg_b = 0;
    tick;
    // Second edge lands while busy
    trg_a = a;
    trg_b = b;
    ns = 1;
    for (int i = 0; i < 2000 && valid !== 1'b1; i++)
    begin
      tick;
      ns += st_a | st_b;
    end
    nv = valid;
    chk(busy, 1'h0);
    repeat (12)
    begin
      tick;
      nv += valid;
      ns += st_a | st_b;
    end
    trg_a = 0;
    trg_b = 0;
    chk(128'(ns), 128'(n));
    chk(128'(nv), 128'h1);
    for (int c = 0; c < CHANNELS; c++)
      if (c < 4 ? a | (code != 0) : b | (code != 0))
        exp_res[c*16 +: 16] = avg(k0, n, c);
    chk(res, exp_res);
    $display("sequence code %0d ends", code);
  endtask : seq
  task automatic ref_test;
    for (int i = 0; i < 4; i++)
    begin
      sel = i[0];
      ext = i[1];
      tick;
      chk({oe, out, bg}, {3{sel}});
      // Status needs a second cycle once the pin is released
      tick;
      chk(ok, sel | ext);
    end
    $display("reference test ends");
  endtask : ref_test
  task automatic cfg_test;
    os = OS_INVALID;
    tick;
    trg_a = 1;
    trg_b = 1;
    repeat (6)
    begin
      tick;
      chk({cerr, st_a, st_b}, 3'h4);
    end
    trg_a = 0;
    trg_b = 0;
    os = OS_NONE;
    tick;
    chk(cerr, 1'h0);
    $display("invalid code test ends");
  endtask : cfg_test
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 0;
    tick;
    tick;
    ref_test;
    for (int c = 0; c < 7; c++)
      seq(c[2:0], 1, 1, c[0]);
    seq(3'h0, 1, 0, 0);
    seq(3'h0, 0, 1, 1);
    cfg_test;
    end_of_test;
  end
  initial
  begin
    #200000;
    error_cnt++;
    end_of_test;
  end
endmodule : tb
